// ==== src/acss_regs.vh ====
`ifndef ACSS_REGS_VH
`define ACSS_REGS_VH
`define ACSS_NCH          16
`define ACSS_NSETUP       8
`define ACSS_REG_ADCMODE  8'h01
`define ACSS_REG_SIF_MODE 8'h02
`define ACSS_REG_CH0      8'h10
`define ACSS_REG_SETUP0   8'h20
`define ACSS_REG_FILT0    8'h28
`define ACSS_REG_OFFS0    8'h30
`define ACSS_REG_GAIN0    8'h38
`define ACSS_REG_CTRL     8'h40
`define ACSS_REG_STATUS   8'h41
`define ACSS_CHAN_ENABLE  15
`define ACSS_CH_SETUP_HI  14
`define ACSS_CH_SETUP_LO  12
`define ACSS_CH_POS_HI    9
`define ACSS_CH_POS_LO    5
`define ACSS_CH_NEG_HI    4
`define ACSS_CH_NEG_LO    0
`define ACSS_SU_REFSEL_HI 5
`define ACSS_SU_REFSEL_LO 4
`define ACSS_SU_CHOPMAX   6
`define ACSS_SU_AINBUF_HI 9
`define ACSS_SU_AINBUF_LO 8
`define ACSS_ADCM_SINGCYC 13
`define ACSS_RST_CH0      16'h8001
`define ACSS_RST_CH       16'h0001
`define ACSS_RST_SETUP    16'h1000
`define ACSS_RST_FILT     16'h0000
`define ACSS_RST_ADCMODE  16'h2000
`define ACSS_RST_SIF_MODE 16'h0000
`define ACSS_RST_OFFSET   24'h800000
`define ACSS_RST_GAIN     24'h555550
`define ACSS_REFSEL_EXT   2'h0
`define ACSS_SLOT_CYCLES  16'h0010
`endif

// ==== src/acss_coef_mem.v ====
`timescale 1ns/1ps
// Offset and gain coefficients, one word per setup, registered read.
module acss_coef_mem (
	input  wire        i_clk,
	input  wire        i_rst,
	input  wire        i_ce,
	input  wire        i_we,
	input  wire [2:0]  i_waddr,
	input  wire [23:0] i_wdata,
	input  wire [2:0]  i_raddr,
	input  wire [23:0] i_rst_val,
	output reg  [23:0] o_rdata
);
	reg [23:0] mem_q [0:7];
	integer k;
	always @(posedge i_clk) begin
		if (i_rst) begin
			for (k = 0; k < 8; k = k + 1) begin
				mem_q[k] <= i_rst_val;
			end
			o_rdata <= 24'h000000;
		end else if (i_ce) begin
			if (i_we) begin
				mem_q[i_waddr] <= i_wdata;
			end
			o_rdata <= mem_q[i_raddr];
		end
	end
endmodule

// ==== src/acss_seq.v ====
`timescale 1ns/1ps
`include "acss_regs.vh"
// Picks the next enabled channel above the current one, wrapping to the lowest.
module acss_seq (
	input  wire        i_clk,
	input  wire        i_rst,
	input  wire        i_ce,
	input  wire        i_run,
	input  wire        i_step,
	input  wire [15:0] i_en,
	output reg  [3:0]  o_cur,
	output reg         o_valid
);
	function [4:0] next_ch;
		input [15:0] en;
		input [3:0]  cur;
		integer j;
		reg [4:0] r;
		reg [3:0] idx;
		begin
			r = 5'h00;
			for (j = 16; j >= 1; j = j - 1) begin
				idx = cur + j[3:0];
				if (en[idx]) begin
					r = {1'b1, idx};
				end
			end
			next_ch = r;
		end
	endfunction
	wire [4:0] nxt = next_ch(i_en, o_cur);
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_cur   <= 4'hF;
			o_valid <= 1'b0;
		end else if (i_ce) begin
			if (!i_run || !nxt[4]) begin
				o_valid <= 1'b0;
			end else if (i_step || !o_valid) begin
				o_cur   <= nxt[3:0];
				o_valid <= 1'b1;
			end
		end
	end
endmodule

// ==== src/acss_top.v ====
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "acss_regs.vh"
// Channel sequencer and setup selection with an AXI4-Lite register slave.
// Byte address is four times the register index.
module acss_top (
	input  wire        i_clk,
	input  wire        i_rst,
	input  wire        i_ce,
	input  wire [9:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [9:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [3:0]  o_channel,
	output reg         o_channel_valid,
	output reg  [4:0]  o_positive_input_select,
	output reg  [4:0]  o_negative_input_select,
	output reg  [2:0]  o_setup,
	output reg  [1:0]  o_ref_select,
	output reg         o_buffer_chop_maximum,
	output reg  [1:0]  o_ain_buffer_enable,
	output reg  [15:0] o_filter_config,
	output reg  [23:0] o_offset,
	output reg  [23:0] o_gain,
	output reg         o_single_cycle_settling,
	output reg         o_conv_strobe
);
	reg  [15:0] ch_q      [0:15];
	reg  [15:0] setup_q   [0:7];
	reg  [15:0] filt_q    [0:7];
	reg  [15:0] adcmode_q;
	reg  [15:0] serial_interface_mode_q;
	reg         run_q;
	reg  [15:0] slot_q;
	reg  [31:0] conv_cnt_q;
	reg  [9:0]  awaddr_q;
	reg         aw_full_q;
	reg  [31:0] wdata_q;
	reg  [3:0]  wstrb_q;
	reg         w_full_q;
	wire [3:0]  cur;
	wire        cur_valid;
	wire        step;
	wire [23:0] offs_rd;
	wire [23:0] gain_rd;
	wire [15:0] en_vec;
	wire [7:0]  widx = awaddr_q[9:2];
	wire [7:0]  ridx = s_axi_araddr[9:2];
	wire        wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
	integer     n;

	function [15:0] merge16;
		input [15:0] old;
		input [31:0] wd;
		input [3:0]  st;
		begin
			merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
		end
	endfunction

	function [2:0] idx_hit;
		input [7:0] idx;
		input [7:0] base;
		begin
			idx_hit = idx[2:0] - base[2:0];
		end
	endfunction

	function in_bank;
		input [7:0] idx;
		input [7:0] base;
		input [4:0] sz;
		begin
			in_bank = (idx >= base) && ({1'b0, idx} < ({1'b0, base} + {4'h0, sz}));
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < `ACSS_NCH; g = g + 1) begin : g_en
			assign en_vec[g] = ch_q[g][`ACSS_CHAN_ENABLE];
		end
	endgenerate

	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready  = !w_full_q;
	assign s_axi_arready = !s_axi_rvalid;
	assign step = run_q && cur_valid && (slot_q == `ACSS_SLOT_CYCLES);

	wire coef_wr_off = wr_go && in_bank(widx, `ACSS_REG_OFFS0, 5'd8);
	wire coef_wr_gn  = wr_go && in_bank(widx, `ACSS_REG_GAIN0, 5'd8);

	acss_coef_mem u_offs (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_ce      (i_ce),
		.i_we      (coef_wr_off),
		.i_waddr   (idx_hit(widx, `ACSS_REG_OFFS0)),
		.i_wdata   (wdata_q[23:0]),
		.i_raddr   (ch_q[cur][`ACSS_CH_SETUP_HI:`ACSS_CH_SETUP_LO]),
		.i_rst_val (`ACSS_RST_OFFSET),
		.o_rdata   (offs_rd)
	);

	acss_coef_mem u_gain (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_ce      (i_ce),
		.i_we      (coef_wr_gn),
		.i_waddr   (idx_hit(widx, `ACSS_REG_GAIN0)),
		.i_wdata   (wdata_q[23:0]),
		.i_raddr   (ch_q[cur][`ACSS_CH_SETUP_HI:`ACSS_CH_SETUP_LO]),
		.i_rst_val (`ACSS_RST_GAIN),
		.o_rdata   (gain_rd)
	);

	acss_seq u_seq (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_ce    (i_ce),
		.i_run   (run_q),
		.i_step  (step),
		.i_en    (en_vec),
		.o_cur   (cur),
		.o_valid (cur_valid)
	);

	// Write channel: address and data latched independently, then applied together.
	always @(posedge i_clk) begin
		if (i_rst) begin
			aw_full_q    <= 1'b0;
			w_full_q     <= 1'b0;
			awaddr_q     <= 10'h000;
			wdata_q      <= 32'h00000000;
			wstrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
			adcmode_q    <= `ACSS_RST_ADCMODE;
			serial_interface_mode_q     <= `ACSS_RST_SIF_MODE;
			run_q        <= 1'b0;
			for (n = 0; n < `ACSS_NCH; n = n + 1) begin
				ch_q[n] <= (n == 0) ? `ACSS_RST_CH0 : `ACSS_RST_CH;
			end
			for (n = 0; n < `ACSS_NSETUP; n = n + 1) begin
				setup_q[n] <= `ACSS_RST_SETUP;
				filt_q[n]  <= `ACSS_RST_FILT;
			end
		end else if (i_ce) begin
			if (s_axi_awvalid && !aw_full_q) begin
				awaddr_q  <= s_axi_awaddr;
				aw_full_q <= 1'b1;
			end
			if (s_axi_wvalid && !w_full_q) begin
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
				w_full_q <= 1'b1;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_go) begin
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'h0;
				if (widx == `ACSS_REG_ADCMODE) begin
					adcmode_q <= merge16(adcmode_q, wdata_q, wstrb_q);
				end else if (widx == `ACSS_REG_SIF_MODE) begin
					serial_interface_mode_q <= merge16(serial_interface_mode_q, wdata_q, wstrb_q);
				end else if (widx == `ACSS_REG_CTRL) begin
					if (wstrb_q[0]) begin
						run_q <= wdata_q[0];
					end
				end else if (in_bank(widx, `ACSS_REG_CH0, 5'd16)) begin
					// Any pin code is accepted on either input.
					ch_q[widx[3:0]] <= merge16(ch_q[widx[3:0]], wdata_q, wstrb_q);
				end else if (in_bank(widx, `ACSS_REG_SETUP0, 5'd8)) begin
					setup_q[widx[2:0]] <= merge16(setup_q[widx[2:0]], wdata_q, wstrb_q);
				end else if (in_bank(widx, `ACSS_REG_FILT0, 5'd8)) begin
					filt_q[widx[2:0]] <= merge16(filt_q[widx[2:0]], wdata_q, wstrb_q);
				end else if (!coef_wr_off && !coef_wr_gn) begin
					s_axi_bresp <= 2'h2;
				end
			end
		end
	end

	// Read channel: one outstanding read, answered the cycle after it is taken.
	// Coefficient reads return the active channel's setup word, not an indexed one.
	always @(posedge i_clk) begin
		if (i_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= 2'h0;
		end else if (i_ce) begin
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (s_axi_arvalid && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'h0;
				s_axi_rdata  <= 32'h00000000;
				if (ridx == `ACSS_REG_ADCMODE) begin
					s_axi_rdata <= {16'h0000, adcmode_q};
				end else if (ridx == `ACSS_REG_SIF_MODE) begin
					s_axi_rdata <= {16'h0000, serial_interface_mode_q};
				end else if (ridx == `ACSS_REG_CTRL) begin
					s_axi_rdata <= {31'h00000000, run_q};
				end else if (ridx == `ACSS_REG_STATUS) begin
					s_axi_rdata <= {conv_cnt_q[26:0], cur_valid, cur};
				end else if (in_bank(ridx, `ACSS_REG_CH0, 5'd16)) begin
					s_axi_rdata <= {16'h0000, ch_q[ridx[3:0]]};
				end else if (in_bank(ridx, `ACSS_REG_SETUP0, 5'd8)) begin
					s_axi_rdata <= {16'h0000, setup_q[ridx[2:0]]};
				end else if (in_bank(ridx, `ACSS_REG_FILT0, 5'd8)) begin
					s_axi_rdata <= {16'h0000, filt_q[ridx[2:0]]};
				end else if (in_bank(ridx, `ACSS_REG_OFFS0, 5'd8)) begin
					s_axi_rdata <= {8'h00, offs_rd};
				end else if (in_bank(ridx, `ACSS_REG_GAIN0, 5'd8)) begin
					s_axi_rdata <= {8'h00, gain_rd};
				end else begin
					s_axi_rresp <= 2'h2;
				end
			end
		end
	end

	// Conversion slot timer; the mux only moves at a slot boundary.
	always @(posedge i_clk) begin
		if (i_rst) begin
			slot_q        <= 16'h0000;
			conv_cnt_q    <= 32'h00000000;
			o_conv_strobe <= 1'b0;
		end else if (i_ce) begin
			o_conv_strobe <= step;
			if (!run_q || !cur_valid || step) begin
				slot_q <= 16'h0000;
			end else begin
				slot_q <= slot_q + 16'h0001;
			end
			if (step) begin
				conv_cnt_q <= conv_cnt_q + 32'h00000001;
			end
		end
	end

	// Setup outputs follow the active channel's setup select.
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_channel               <= 4'h0;
			o_channel_valid         <= 1'b0;
			o_positive_input_select <= 5'h00;
			o_negative_input_select <= 5'h00;
			o_setup                 <= 3'h0;
			o_ref_select            <= `ACSS_REFSEL_EXT;
			o_buffer_chop_maximum   <= 1'b0;
			o_ain_buffer_enable     <= 2'h0;
			o_filter_config         <= `ACSS_RST_FILT;
			o_offset                <= `ACSS_RST_OFFSET;
			o_gain                  <= `ACSS_RST_GAIN;
			o_single_cycle_settling <= 1'b1;
		end else if (i_ce) begin
			o_channel               <= cur;
			o_channel_valid         <= cur_valid;
			o_positive_input_select <= ch_q[cur][`ACSS_CH_POS_HI:`ACSS_CH_POS_LO];
			o_negative_input_select <= ch_q[cur][`ACSS_CH_NEG_HI:`ACSS_CH_NEG_LO];
			o_setup                 <= ch_q[cur][`ACSS_CH_SETUP_HI:`ACSS_CH_SETUP_LO];
			o_ref_select            <= setup_q[o_setup][`ACSS_SU_REFSEL_HI:`ACSS_SU_REFSEL_LO];
			o_buffer_chop_maximum   <= setup_q[o_setup][`ACSS_SU_CHOPMAX];
			o_ain_buffer_enable     <= setup_q[o_setup][`ACSS_SU_AINBUF_HI:`ACSS_SU_AINBUF_LO];
			o_filter_config         <= filt_q[o_setup];
			o_offset                <= offs_rd;
			o_gain                  <= gain_rd;
			o_single_cycle_settling <= adcmode_q[`ACSS_ADCM_SINGCYC];
		end
	end
endmodule

// ==== dv/acss_monitor.sv ====
`timescale 1ns/1ps
module acss_monitor (
	input wire        i_clk,
	input wire        i_rst,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire [3:0]  o_channel,
	input wire        o_channel_valid,
	input wire [1:0]  o_ref_select,
	input wire [23:0] o_offset,
	input wire        o_conv_strobe
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_slot_spacing: assert property (o_conv_strobe |=> !o_conv_strobe [*8])
		else $error("conversion strobes closer than a slot");
	// A channel may only move at a slot end, so enable edits cut a slot short only by disabling every channel.
	a_move_on_slot: assert property (o_channel_valid && $past(o_channel_valid) &&
		$changed(o_channel) |-> o_conv_strobe || $past(o_conv_strobe))
		else $error("channel changed inside a slot");
	a_reset_defaults: assert property ($fell(i_rst) |-> o_ref_select == 2'h0 &&
		o_offset == 24'h800000 && !o_channel_valid)
		else $error("outputs not at reset values");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##[1:3] s_axi_bvalid)
		else $error("write answer late");
	a_bresp_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	cover property (o_conv_strobe);
	cover property ($rose(o_channel_valid));
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind acss_top acss_monitor u_mon (.*);

// ==== dv/adc_channel_sequencer_setup_select_tb.sv ====
`timescale 1ns/1ps
`include "acss_regs.vh"
module adc_channel_sequencer_setup_select_tb;
	reg         i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1;
	reg  [9:0]  s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
	reg  [31:0] s_axi_wdata = 32'h00000000;
	reg  [3:0]  s_axi_wstrb = 4'hF;
	reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp, o_ref_select, o_ain_buffer_enable;
	wire [31:0] s_axi_rdata;
	wire [3:0]  o_channel;
	wire        o_channel_valid, o_buffer_chop_maximum, o_single_cycle_settling, o_conv_strobe;
	wire [4:0]  o_positive_input_select, o_negative_input_select;
	wire [2:0]  o_setup;
	wire [15:0] o_filter_config;
	wire [23:0] o_offset, o_gain;
	integer     error_cnt = 0, num_checks = 0, i;
	reg  [31:0] d;
	reg  [1:0]  r;
	localparam [11:0] e_ch = {4'h9, 4'h3, 4'h0};
	localparam [8:0]  e_su = {3'h2, 3'h5, 3'h0};
	localparam [14:0] e_p  = {5'h0F, 5'h08, 5'h00};
	localparam [14:0] e_n  = {5'h10, 5'h10, 5'h01};
	localparam [5:0]  e_r  = {2'h2, 2'h1, 2'h0};
	localparam [2:0]  e_c  = {1'b0, 1'b1, 1'b0};
	localparam [5:0]  e_b  = {2'h0, 2'h3, 2'h0};
	localparam [71:0] e_o  = {24'h800000, 24'h123456, 24'h800000};
	always #12.5 i_clk = ~i_clk;
	acss_top u_dut (.*);
	task automatic check(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				error_cnt = error_cnt + 1;
				$display("ERROR %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task automatic complete_run;
		begin
			$display("checks %0d mismatches %0d", num_checks, error_cnt);
			if (error_cnt == 0 && num_checks > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	// Handshakes are judged at the falling edge, where the ready lines have settled, and
	// acted on at the next rising edge; sampling at the rising edge itself would race the slave.
	task automatic axw(input [9:0] a, input [31:0] dv, output [1:0] rs);
		integer n;
		reg     aw_hs, w_hs, b_hs;
		begin
			rs = 2'h3;
			@(posedge i_clk);
			s_axi_awaddr <= a;
			s_axi_wdata <= dv;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			for (n = 0; n < 64 && rs === 2'h3; n = n + 1) begin
				@(negedge i_clk);
				aw_hs = s_axi_awvalid && s_axi_awready;
				w_hs = s_axi_wvalid && s_axi_wready;
				b_hs = s_axi_bvalid && s_axi_bready;
				if (b_hs)
					rs = s_axi_bresp;
				@(posedge i_clk);
				if (aw_hs)
					s_axi_awvalid <= 1'b0;
				if (w_hs)
					s_axi_wvalid <= 1'b0;
				if (b_hs)
					s_axi_bready <= 1'b0;
			end
			@(posedge i_clk);
		end
	endtask
	task automatic axr(input [9:0] a, output [31:0] dv, output [1:0] rs);
		integer n;
		reg     ar_hs, r_hs;
		begin
			rs = 2'h3;
			@(posedge i_clk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			for (n = 0; n < 64 && rs === 2'h3; n = n + 1) begin
				@(negedge i_clk);
				ar_hs = s_axi_arvalid && s_axi_arready;
				r_hs = s_axi_rvalid && s_axi_rready;
				if (r_hs) begin
					dv = s_axi_rdata;
					rs = s_axi_rresp;
				end
				@(posedge i_clk);
				if (ar_hs)
					s_axi_arvalid <= 1'b0;
				if (r_hs)
					s_axi_rready <= 1'b0;
			end
			@(posedge i_clk);
		end
	endtask
	task automatic wreg(input [7:0] idx, input [31:0] dv);
		begin
			axw({idx, 2'b00}, dv, r);
			check("bresp", r, 2'h0);
		end
	endtask
	task automatic rchk(input string nm, input [7:0] idx, input [31:0] exp);
		begin
			axr({idx, 2'b00}, d, r);
			check(nm, d, exp);
			check("rresp", r, 2'h0);
		end
	endtask
	// Sampling four cycles into a slot lets the lagging setup and coefficient outputs settle.
	task automatic next_slot;
		integer k;
		begin
			for (k = 0; k < 64 && o_conv_strobe !== 1'b1; k = k + 1)
				@(negedge i_clk);
			repeat (4) @(negedge i_clk);
		end
	endtask
	initial begin
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		check("ref_select", o_ref_select, 2'h0);
		check("offset", o_offset, 24'h800000);
		check("gain", o_gain, `ACSS_RST_GAIN);
		check("filter", o_filter_config, 16'h0000);
		check("single_cycle_settling", o_single_cycle_settling, 1'b1);
		rchk("ch0", `ACSS_REG_CH0, 32'h8001);
		rchk("ch1", `ACSS_REG_CH0 + 8'h01, 32'h0001);
		rchk("setup0", `ACSS_REG_SETUP0, 32'h1000);
		rchk("if_mode", `ACSS_REG_SIF_MODE, 32'h0000);
		wreg(`ACSS_REG_SIF_MODE, 32'h00001C85);
		rchk("if_mode", `ACSS_REG_SIF_MODE, 32'h1C85);
		axw(10'h140, 32'h00000001, r);
		check("bad_bresp", r, 2'h2);
		axr(10'h140, d, r);
		check("bad_rdata", d, 32'h0);
		check("bad_rresp", r, 2'h2);
		$display("test reset_and_access done");
		wreg(`ACSS_REG_CH0 + 8'h03, 32'h0000D110);
		wreg(`ACSS_REG_CH0 + 8'h09, 32'h0000A1F0);
		wreg(`ACSS_REG_SETUP0 + 8'h05, 32'h00000350);
		wreg(`ACSS_REG_SETUP0 + 8'h02, 32'h00000020);
		wreg(`ACSS_REG_OFFS0 + 8'h05, 32'h00123456);
		wreg(`ACSS_REG_CTRL, 32'h00000001);
		repeat (4) @(negedge i_clk);
		for (i = 0; i < 7; i = i + 1) begin
			if (i > 0)
				next_slot;
			check("valid", o_channel_valid, 1'b1);
			check("channel", o_channel, e_ch[(i % 3) * 4 +: 4]);
			check("setup", o_setup, e_su[(i % 3) * 3 +: 3]);
			check("pos", o_positive_input_select, e_p[(i % 3) * 5 +: 5]);
			check("neg", o_negative_input_select, e_n[(i % 3) * 5 +: 5]);
			check("ref", o_ref_select, e_r[(i % 3) * 2 +: 2]);
			check("chop", o_buffer_chop_maximum, e_c[i % 3]);
			check("buf", o_ain_buffer_enable, e_b[(i % 3) * 2 +: 2]);
			check("offset", o_offset, e_o[(i % 3) * 24 +: 24]);
		end
		$display("test scan_sequence done");
		wreg(`ACSS_REG_CH0 + 8'h03, 32'h00005110);
		wreg(`ACSS_REG_CH0 + 8'h09, 32'h000021F0);
		next_slot;
		next_slot;
		for (i = 0; i < 3; i = i + 1) begin
			next_slot;
			check("lone_channel", o_channel, 4'h0);
		end
		wreg(`ACSS_REG_ADCMODE, 32'h00000000);
		next_slot;
		check("single_cycle_settling_off", o_single_cycle_settling, 1'b0);
		wreg(`ACSS_REG_ADCMODE, 32'h00002000);
		wreg(`ACSS_REG_CH0, 32'h00000001);
		next_slot;
		next_slot;
		check("none_valid", o_channel_valid, 1'b0);
		$display("test lone_and_none done");
		complete_run;
	end
	initial begin
		#100000;
		error_cnt = error_cnt + 1;
		$display("ERROR watchdog expired");
		complete_run;
	end
endmodule
